//--- rtl/ish_pkg.sv
// Constants for the ISA subset helper block
package ish_pkg;
  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_FP_CONTROL_STATUS_REG    = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_EVENT   = 8'h0C;
  localparam logic [7:0] ADDR_IMPL    = 8'h10;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CC0_BIT         = 23;
  localparam int CCN_BASE        = 24;
  localparam int STATUS_SUP_BIT  = 3;
  localparam int CFG_FPU_BIT     = 0;
  localparam int CFG_CP2_BIT     = 1;
  localparam int CFG_AT_LSB      = 2;
  localparam int CFG_MT_LSB      = 4;
  localparam int IMPL_PS_BIT     = 0;
  // Reserved (zero) bits of the control/status image
  localparam logic [31:0] FP_CONTROL_STATUS_REG_WMASK   = 32'hFFBF_FFFF;
  localparam logic [31:0] FP_CONTROL_STATUS_REG_RST     = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST   = 32'h0000_0000;
  // ------------------------------------------------------------
  // Exception codes
  // ------------------------------------------------------------
  localparam logic [4:0] EXC_NONE  = 5'h00;
  localparam logic [4:0] EXC_RI    = 5'h0A;
  localparam logic [4:0] EXC_CPU   = 5'h0B;
  localparam logic [4:0] EXC_DBP   = 5'h1E;
  localparam logic [4:0] EXC_DMBP  = 5'h1F;
  // Instruction classes presented by the decode stage
  typedef enum logic [3:0]
  {
    ISH_CLS_INT   = 4'h0,
    ISH_CLS_JREG  = 4'h1,
    ISH_CLS_FPU   = 4'h2,
    ISH_CLS_FPPS  = 4'h3,
    ISH_CLS_MOVFT = 4'h4,
    ISH_CLS_CP2   = 4'h5,
    ISH_CLS_SYNC  = 4'h6,
    ISH_CLS_BRL   = 4'h7,
    ISH_CLS_SUP   = 4'h8
  } ish_cls_e;
  // Sync sequencing states
  typedef enum logic [1:0]
  {
    ISH_SY_IDLE = 2'b01,
    ISH_SY_WAIT = 2'b10
  } ish_sync_e;
endpackage

//--- rtl/ish_core.sv
// Helper logic: condition codes, word check, slots, exceptions, options
//
// Operation
// - Condition code read selects bit 23 or 24+n
// - Condition code write changes only selected bit
// - Flag value when upper bits differ bit 31
// - Delay slot follows any register jump or branch-likely
// - Exception aborts instruction, carries code and argument
// - Breakpoint outside debug mode enters debug mode
// - Exception in debug mode uses debug breakpoint path
// - Nullify aborts; a branch-likely that is not taken kills its delay slot
// - Forward function field to selected coprocessor unit
// - Sync orders selected loads and stores globally
// - Base integer instructions always implemented
// - FPU optional with flag reporting its presence
// - FPU absent, or base formats, or plus paired
// - Second coprocessor optional, its instructions individually
// - 32-bit address space forces 64-bit addressing off
// - MMU kind reported in type field
// - Reserved fields carry no meaning
// - Omitted instruction raises reserved or unusable exception
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ish_core
#(
  parameter bit         HAS_FPU   = 1'b1,
  parameter bit         HAS_PS    = 1'b1,
  parameter bit         HAS_CP2   = 1'b1,
  parameter logic [11:0] CP2_IMPL = 12'hFFF,
  parameter bit         ADDR64    = 1'b1,
  parameter bit         HAS_SUP   = 1'b0,
  parameter logic [1:0] MMU_KIND  = 2'h1
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Issue from decode
  input  wire logic        iss_valid,
  input  wire logic [3:0]  iss_class,
  input  wire logic [3:0]  iss_cp2_op,
  input  wire logic [1:0]  iss_cop_unit,
  input  wire logic [24:0] iss_cop_fun,
  input  wire logic [4:0]  iss_sync_type,
  input  wire logic        iss_branch_taken,
  input  wire logic        iss_dbg_bp,
  input  wire logic        iss_exc_req,
  input  wire logic [4:0]  iss_exc_code,
  input  wire logic [31:0] iss_exc_arg,
  input  wire logic        dbg_mode,
  // Condition code access
  input  wire logic [2:0]  condition_code_index,
  input  wire logic        cc_wr,
  input  wire logic        cc_wdata,
  output logic             cc_rdata,
  // Word check
  input  wire logic [63:0] chk_value,
  output logic             not_word,
  // Slot and abort results
  output logic             in_delay_slot,
  output logic             abort,
  output logic             commit_en,
  output logic             exc_valid,
  output logic [4:0]       exc_code,
  output logic [31:0]      exc_arg,
  output logic             dbg_enter,
  output logic             dbg_reenter,
  // Coprocessor dispatch
  output logic             cop_valid,
  output logic [3:0]       cop_sel,
  output logic [24:0]      cop_fun,
  // Memory ordering
  output logic             sync_req,
  output logic [4:0]       sync_type,
  input  wire logic        sync_done,
  output logic             issue_stall,
  output logic             addr64_en
);
  // ----------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------
  logic rst_meta_ff;
  logic rst_ff;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_ff      <= rst_meta_ff;
    end
  end
  wire logic srst_n = rst_ff;

  // ----------------------------------------------------------
  // Register state and configuration images
  // ----------------------------------------------------------
  logic [31:0] fp_control_status_reg_ff;
  logic [31:0] status_ff;
  logic        addr64_req_ff;
  logic [31:0] config_reg_one;
  logic [31:0] fpu_implementation_reg;
  logic        fpu_present_flag;
  logic        second_coprocessor_present;
  logic [1:0]  address_space_width_field;
  logic [1:0]  mmu_kind_field;
  logic        paired_single_format;
  logic [31:0] evt_ff;

  assign fpu_present_flag           = HAS_FPU;
  assign paired_single_format       = HAS_FPU & HAS_PS;
  assign second_coprocessor_present = HAS_CP2;
  assign address_space_width_field  = ADDR64 ? 2'h2 : 2'h0;
  assign mmu_kind_field             = MMU_KIND;
  always_comb
  begin
    config_reg_one = 32'h0000_0000;
    config_reg_one[ish_pkg::CFG_FPU_BIT] = fpu_present_flag;
    config_reg_one[ish_pkg::CFG_CP2_BIT] = second_coprocessor_present;
    config_reg_one[ish_pkg::CFG_AT_LSB +: 2] = address_space_width_field;
    config_reg_one[ish_pkg::CFG_MT_LSB +: 2] = mmu_kind_field;
    fpu_implementation_reg = 32'h0000_0000;
    fpu_implementation_reg[ish_pkg::IMPL_PS_BIT] = paired_single_format;
  end

  // 64-bit addressing is only granted with a full address space
  assign addr64_en = addr64_req_ff & ADDR64;

  // ----------------------------------------------------------
  // APB slave: zero wait states
  // ----------------------------------------------------------
  logic apb_wr;
  logic apb_hit;
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  always_comb
  begin
    apb_hit = 1'b1;
    prdata  = 32'h0000_0000;
    unique case (paddr)
      ish_pkg::ADDR_FP_CONTROL_STATUS_REG:   prdata = fp_control_status_reg_ff;
      ish_pkg::ADDR_CFG:    prdata = config_reg_one;
      ish_pkg::ADDR_STATUS: prdata = status_ff;
      ish_pkg::ADDR_EVENT:  prdata = evt_ff;
      ish_pkg::ADDR_IMPL:   prdata = fpu_implementation_reg;
      default:              apb_hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~apb_hit;

  // ----------------------------------------------------------
  // Floating-point control/status and condition codes
  // ----------------------------------------------------------
  logic [5:0] cc_pos;
  assign cc_pos = (condition_code_index == 3'h0) ? 6'(ish_pkg::CC0_BIT)
                : 6'(ish_pkg::CCN_BASE) + 6'(condition_code_index);
  assign cc_rdata = fp_control_status_reg_ff[cc_pos[4:0]];

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      fp_control_status_reg_ff <= ish_pkg::FP_CONTROL_STATUS_REG_RST;
    else if (cc_wr)
      fp_control_status_reg_ff[cc_pos[4:0]] <= cc_wdata;
    else if (apb_wr && paddr == ish_pkg::ADDR_FP_CONTROL_STATUS_REG && HAS_FPU)
      fp_control_status_reg_ff <= pwdata & ish_pkg::FP_CONTROL_STATUS_REG_WMASK;
  end

  // ----------------------------------------------------------
  // Status register and addressing request
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      status_ff     <= ish_pkg::STATUS_RST;
      addr64_req_ff <= 1'b0;
    end
    else if (apb_wr && paddr == ish_pkg::ADDR_STATUS)
    begin
      status_ff <= pwdata;
      if (!HAS_SUP)
        status_ff[ish_pkg::STATUS_SUP_BIT] <= 1'b0;
      addr64_req_ff <= pwdata[31];
    end
  end

  // ----------------------------------------------------------
  // Word value check
  // ----------------------------------------------------------
  assign not_word = (chk_value[63:32] != {32{chk_value[31]}});

  // ----------------------------------------------------------
  // Delay slot tracking
  // ----------------------------------------------------------
  logic jslot_ff;
  logic lslot_ff;
  logic kill_slot_ff;
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      jslot_ff     <= 1'b0;
      lslot_ff     <= 1'b0;
      kill_slot_ff <= 1'b0;
    end
    else if (iss_valid && !issue_stall)
    begin
      jslot_ff     <= (iss_class == ish_pkg::ISH_CLS_JREG) && !abort;
      lslot_ff     <= (iss_class == ish_pkg::ISH_CLS_BRL) && !abort;
      kill_slot_ff <= (iss_class == ish_pkg::ISH_CLS_BRL)
                      && !iss_branch_taken && !abort;
    end
  end
  assign in_delay_slot = jslot_ff | lslot_ff;

  // ----------------------------------------------------------
  // Omitted-instruction detection
  // ----------------------------------------------------------
  logic omit_ri;
  logic omit_cpu;
  always_comb
  begin
    omit_ri  = 1'b0;
    omit_cpu = 1'b0;
    unique case (iss_class)
      ish_pkg::ISH_CLS_FPU,
      ish_pkg::ISH_CLS_MOVFT: omit_cpu = !HAS_FPU;
      ish_pkg::ISH_CLS_FPPS:  omit_ri  = !(HAS_FPU && HAS_PS);
      ish_pkg::ISH_CLS_CP2:   omit_cpu = !HAS_CP2
                                 || !CP2_IMPL[iss_cp2_op];
      ish_pkg::ISH_CLS_SUP:   omit_ri  = !HAS_SUP;
      default:                omit_ri  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Exception priority and abort
  // ----------------------------------------------------------
  logic [4:0] nxt_code;
  logic       nxt_exc;
  logic       nullify;
  assign nullify = iss_valid & kill_slot_ff;
  always_comb
  begin
    nxt_exc  = 1'b0;
    nxt_code = ish_pkg::EXC_NONE;
    if (iss_valid && !nullify)
    begin
      if (dbg_mode && (iss_exc_req || iss_dbg_bp || omit_ri || omit_cpu))
      begin
        nxt_exc  = 1'b1;
        nxt_code = ish_pkg::EXC_DMBP;
      end
      else if (iss_dbg_bp)
      begin
        nxt_exc  = 1'b1;
        nxt_code = ish_pkg::EXC_DBP;
      end
      else if (omit_cpu)
      begin
        nxt_exc  = 1'b1;
        nxt_code = ish_pkg::EXC_CPU;
      end
      else if (omit_ri)
      begin
        nxt_exc  = 1'b1;
        nxt_code = ish_pkg::EXC_RI;
      end
      else if (iss_exc_req)
      begin
        nxt_exc  = 1'b1;
        nxt_code = iss_exc_code;
      end
    end
  end
  assign abort       = nxt_exc | nullify;
  assign commit_en   = iss_valid & ~abort & ~issue_stall;
  assign dbg_enter   = nxt_exc & (nxt_code == ish_pkg::EXC_DBP);
  assign dbg_reenter = nxt_exc & (nxt_code == ish_pkg::EXC_DMBP);

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      exc_valid <= 1'b0;
      exc_code  <= ish_pkg::EXC_NONE;
      exc_arg   <= 32'h0000_0000;
    end
    else
    begin
      exc_valid <= nxt_exc;
      if (nxt_exc)
      begin
        exc_code <= nxt_code;
        exc_arg  <= iss_exc_arg;
      end
    end
  end

  // Sticky event image, set wins over write-one clear
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      evt_ff <= 32'h0000_0000;
    else
      evt_ff <= (evt_ff & ~((apb_wr && paddr == ish_pkg::ADDR_EVENT)
                 ? pwdata : 32'h0000_0000))
                | {29'h0, dbg_reenter, dbg_enter, nxt_exc};
  end

  // ----------------------------------------------------------
  // Coprocessor dispatch
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      cop_valid <= 1'b0;
      cop_sel   <= 4'h0;
      cop_fun   <= 25'h000_0000;
    end
    else
    begin
      cop_valid <= commit_en && iss_class == ish_pkg::ISH_CLS_CP2;
      if (commit_en && iss_class == ish_pkg::ISH_CLS_CP2)
      begin
        cop_sel <= 4'(4'h1 << iss_cop_unit);
        cop_fun <= iss_cop_fun;
      end
    end
  end

  // ----------------------------------------------------------
  // Sync sequencer: issue stalls until memory reports order
  // ----------------------------------------------------------
  ish_pkg::ish_sync_e sy_ff;
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      sy_ff     <= ish_pkg::ISH_SY_IDLE;
      sync_type <= 5'h00;
    end
    else
    begin
      unique case (sy_ff)
        ish_pkg::ISH_SY_IDLE:
          if (iss_valid && !abort && iss_class == ish_pkg::ISH_CLS_SYNC)
          begin
            sy_ff     <= ish_pkg::ISH_SY_WAIT;
            sync_type <= iss_sync_type;
          end
        ish_pkg::ISH_SY_WAIT:
          if (sync_done)
            sy_ff <= ish_pkg::ISH_SY_IDLE;
        default:
          sy_ff <= ish_pkg::ISH_SY_IDLE;
      endcase
    end
  end
  assign sync_req    = (sy_ff == ish_pkg::ISH_SY_WAIT);
  assign issue_stall = sync_req;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  cc_read_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (condition_code_index == 3'h0) |-> cc_rdata == fp_control_status_reg_ff[23])
    else $error("cc0 read wrong bit");
  cc_write_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (cc_wr && condition_code_index == 3'h2) |=>
    fp_control_status_reg_ff[26] == $past(cc_wdata)
    && fp_control_status_reg_ff[25:0] == $past(fp_control_status_reg_ff[25:0]))
    else $error("cc write disturbed other bits");
  word_chk_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (chk_value[63] != chk_value[31]) |-> not_word)
    else $error("bad word not flagged");
  jslot_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (iss_valid && !issue_stall && !abort
     && iss_class == ish_pkg::ISH_CLS_JREG) |=> in_delay_slot)
    else $error("delay slot missed");
  exc_arg_a: assert property (@(posedge mclk) disable iff (!srst_n)
    nxt_exc |=> exc_valid && exc_arg == $past(iss_exc_arg))
    else $error("exception argument lost");
  dbg_in_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (iss_valid && !nullify && iss_dbg_bp && !dbg_mode) |-> dbg_enter && abort)
    else $error("debug entry missed");
  dbg_re_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (iss_valid && !nullify && iss_exc_req && dbg_mode) |-> dbg_reenter
    && !dbg_enter)
    else $error("debug reentry missed");
  null_kill_a: assert property (@(posedge mclk) disable iff (!srst_n)
    nullify |-> abort && !commit_en)
    else $error("nullified slot committed");
  cop_fun_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (commit_en && iss_class == ish_pkg::ISH_CLS_CP2) |=>
    cop_valid && cop_fun == $past(iss_cop_fun))
    else $error("coprocessor function lost");
  sync_hold_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (sync_req && !sync_done) |=> sync_req && !commit_en)
    else $error("sync released early");
  sup_zero_a: assert property (@(posedge mclk) disable iff (!srst_n)
    !HAS_SUP |-> status_ff[3] == 1'b0)
    else $error("supervisor bit not zero");
  no_commit_a: assert property (@(posedge mclk) disable iff (!srst_n)
    abort |-> !commit_en)
    else $error("aborted instruction committed");
  cp2_omit_a: assert property (@(posedge mclk) disable iff (!srst_n)
    (iss_valid && !dbg_mode && !nullify && !iss_dbg_bp
     && iss_class == ish_pkg::ISH_CLS_CP2 && !HAS_CP2) |=>
    exc_code == ish_pkg::EXC_CPU)
    else $error("omitted coprocessor not trapped");
  exc_c: cover property (@(posedge mclk) disable iff (!srst_n) exc_valid);
  sync_c: cover property (@(posedge mclk) disable iff (!srst_n)
    sync_req ##1 !sync_req);
  null_c: cover property (@(posedge mclk) disable iff (!srst_n) nullify);
  dbg_c: cover property (@(posedge mclk) disable iff (!srst_n) dbg_reenter);
endmodule
`default_nettype wire

//--- verif/ish_cop_model.sv
// Coprocessor and memory-ordering partner model
`timescale 1ns/1ps
`default_nettype none
module ish_cop_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Coprocessor dispatch
  input  wire logic        cop_valid,
  input  wire logic [3:0]  cop_sel,
  input  wire logic [24:0] cop_fun,
  output logic      [3:0]  got_sel,
  output logic      [24:0] got_fun,
  // Memory ordering
  input  wire logic        sync_req,
  input  wire logic [3:0]  dly,
  output logic             sync_done,
  output int               n_sync
);
  logic [3:0] wait_ff;
  // ----------------------------------------------------------
  // Function code capture
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      got_sel <= 4'h0;
      got_fun <= 25'h0;
    end
    else if (cop_valid)
    begin
      got_sel <= cop_sel;
      got_fun <= cop_fun;
    end
  end
  // ----------------------------------------------------------
  // Ordering completes dly+1 cycles after sync_req is first seen
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_done <= 1'b0;
      wait_ff   <= 4'h0;
      n_sync    <= 0;
    end
    else if (sync_done)
    begin
      sync_done <= 1'b0;
      wait_ff   <= 4'h0;
      n_sync    <= n_sync + 1;
    end
    else if (sync_req && wait_ff >= dly)
      sync_done <= 1'b1;
    else if (sync_req)
      wait_ff <= wait_ff + 4'h1;
  end
endmodule
`default_nettype wire

//--- verif/tb_isa_subset_and_helper_logic.sv
// Self-checking bench for the ISA subset helper block
`timescale 1ns/1ps
`default_nettype none
module tb_isa_subset_and_helper_logic;
  localparam logic [1:0] MT = 2'h2;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        iss_valid = 0, iss_branch_taken = 0, iss_dbg_bp = 0;
  logic        iss_exc_req = 0, dbg_mode = 0, cc_wr = 0, cc_wdata = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, iss_exc_arg = '0;
  logic [3:0]  iss_class = '0, iss_cp2_op = '0, dly = '0;
  logic [1:0]  iss_cop_unit = '0;
  logic [24:0] iss_cop_fun = '0;
  logic [4:0]  iss_sync_type = '0, iss_exc_code = '0;
  logic [2:0]  condition_code_index = '0;
  logic [63:0] chk_value = '0;
  logic [31:0] prdata, exc_arg, fp_control_status_reg, r, w;
  logic [3:0]  cop_sel, got_sel;
  logic [24:0] cop_fun, got_fun, f;
  logic [4:0]  exc_code, sync_type, t;
  logic [7:0]  last;
  logic [63:0] v;
  logic        pready, pslverr, cc_rdata, not_word, in_delay_slot, abort;
  logic        commit_en, exc_valid, dbg_enter, dbg_reenter, cop_valid;
  logic        sync_req, sync_done, issue_stall, addr64_en, e, b;
  int          n_errors = 0, samples_checked = 0, n_sync, n, p;

  ish_core #(.HAS_FPU(1'b1), .HAS_PS(1'b0), .HAS_CP2(1'b1),
    .CP2_IMPL(12'hFFE), .ADDR64(1'b1), .HAS_SUP(1'b0), .MMU_KIND(MT)) dut
  (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .iss_valid(iss_valid),
    .iss_class(iss_class), .iss_cp2_op(iss_cp2_op),
    .iss_cop_unit(iss_cop_unit), .iss_cop_fun(iss_cop_fun),
    .iss_sync_type(iss_sync_type), .iss_branch_taken(iss_branch_taken),
    .iss_dbg_bp(iss_dbg_bp), .iss_exc_req(iss_exc_req),
    .iss_exc_code(iss_exc_code), .iss_exc_arg(iss_exc_arg),
    .dbg_mode(dbg_mode), .condition_code_index(condition_code_index),
    .cc_wr(cc_wr), .cc_wdata(cc_wdata), .cc_rdata(cc_rdata),
    .chk_value(chk_value), .not_word(not_word),
    .in_delay_slot(in_delay_slot), .abort(abort), .commit_en(commit_en),
    .exc_valid(exc_valid), .exc_code(exc_code), .exc_arg(exc_arg),
    .dbg_enter(dbg_enter), .dbg_reenter(dbg_reenter),
    .cop_valid(cop_valid), .cop_sel(cop_sel), .cop_fun(cop_fun),
    .sync_req(sync_req), .sync_type(sync_type), .sync_done(sync_done),
    .issue_stall(issue_stall), .addr64_en(addr64_en)
  );
  ish_cop_model far
  (
    .mclk(mclk), .rst_n(rst_n), .cop_valid(cop_valid), .cop_sel(cop_sel),
    .cop_fun(cop_fun), .got_sel(got_sel), .got_fun(got_fun),
    .sync_req(sync_req), .dly(dly), .sync_done(sync_done), .n_sync(n_sync)
  );
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] x,
                     input logic [63:0] g);
    samples_checked++;
    if (g !== x)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Flags sampled: abort commit enter reenter slot exc cop sync
  task automatic step(input logic vl, input logic [3:0] c, input logic x,
                      input logic bp, input logic tk,
                      input logic [7:0] ex, input logic [7:0] m);
    iss_valid        <= vl;
    iss_class        <= c;
    iss_exc_req      <= x;
    iss_dbg_bp       <= bp;
    iss_branch_taken <= tk;
    @(negedge mclk);
    last = {abort, commit_en, dbg_enter, dbg_reenter, in_delay_slot,
            exc_valid, cop_valid, sync_req};
    chk("flags", ex & m, last & m);
    @(posedge mclk);
  endtask
  task automatic exc_case(input logic dm, input logic x, input logic bp,
                          input logic [4:0] ec, input logic [1:0] en);
    logic [4:0]  c;
    logic [31:0] a;
    c = 5'($urandom_range(1, 9));
    a = $urandom;
    dbg_mode     <= dm;
    iss_exc_code <= c;
    iss_exc_arg  <= a;
    step(1, ish_pkg::ISH_CLS_INT, x, bp, 0, {2'b10, en, 4'h0}, 8'hF0);
    step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h04, 8'h04);
    chk("exc_code", (ec === ish_pkg::EXC_NONE) ? c : ec, exc_code);
    if (ec === ish_pkg::EXC_NONE)
      chk("exc_arg", a, exc_arg);
    dbg_mode <= 1'b0;
  endtask
  // ----------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------
  initial
    forever #12.5 mclk = ~mclk;
  initial
  begin
    #(25 * 4000);
    n_errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(71));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(0, ish_pkg::ADDR_CFG, 0);
    chk("cfg", {MT, 2'h2, 2'h3}, r[5:0]);
    apb(0, ish_pkg::ADDR_IMPL, 0);
    chk("impl_ps", 1'b0, r[0]);
    apb(0, 8'h20, 0);
    chk("unmapped", {1'b1, 32'h0}, {e, r});
    w = $urandom;
    apb(1, ish_pkg::ADDR_FP_CONTROL_STATUS_REG, w);
    apb(0, ish_pkg::ADDR_FP_CONTROL_STATUS_REG, 0);
    fp_control_status_reg = w & ish_pkg::FP_CONTROL_STATUS_REG_WMASK;
    chk("fp_control_status_reg", fp_control_status_reg, r);
    for (int i = 0; i < 8; i++)
    begin
      p = (i == 0) ? 23 : 24 + i;
      b = ~fp_control_status_reg[p];
      condition_code_index <= 3'(i);
      cc_wr                <= 1'b1;
      cc_wdata             <= b;
      @(negedge mclk);
      chk("cc_old", fp_control_status_reg[p], cc_rdata);
      @(posedge mclk);
      cc_wr <= 1'b0;
      fp_control_status_reg[p] = b;
      @(negedge mclk);
      chk("cc_new", b, cc_rdata);
      @(posedge mclk);
    end
    apb(0, ish_pkg::ADDR_FP_CONTROL_STATUS_REG, 0);
    chk("fp_control_status_reg_cc", fp_control_status_reg, r);
    for (int k = 0; k < 32; k++)
    begin
      v = {$urandom, $urandom};
      if (k % 3 != 0)
        v[63:32] = {32{v[31]}};
      if (k % 3 == 1)
        v[32 + k] = ~v[32 + k];
      chk_value <= v;
      @(negedge mclk);
      chk("not_word", v[63:32] != {32{v[31]}}, not_word);
      @(posedge mclk);
    end
    step(1, ish_pkg::ISH_CLS_JREG, 0, 0, 0, 8'h40, 8'hC0);
    step(1, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h48, 8'hC8);
    step(1, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h40, 8'hC8);
    step(1, ish_pkg::ISH_CLS_BRL, 0, 0, 0, 8'h40, 8'hC0);
    step(1, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h88, 8'hC8);
    step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h00, 8'h04);
    step(1, ish_pkg::ISH_CLS_MOVFT, 0, 0, 0, 8'h40, 8'hC0);
    step(1, ish_pkg::ISH_CLS_BRL, 0, 0, 1, 8'h40, 8'hC0);
    step(1, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h48, 8'hC8);
    exc_case(0, 1, 0, ish_pkg::EXC_NONE, 2'b00);
    exc_case(0, 0, 1, ish_pkg::EXC_DBP, 2'b10);
    exc_case(1, 1, 0, ish_pkg::EXC_DMBP, 2'b01);
    iss_cp2_op <= 4'h0;
    for (int k = 0; k < 2; k++)
    begin
      step(1, k ? ish_pkg::ISH_CLS_CP2 : ish_pkg::ISH_CLS_FPPS, 0, 0, 0,
           8'h80, 8'hC2);
      step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h04, 8'h06);
      chk("omit", k ? ish_pkg::EXC_CPU : ish_pkg::EXC_RI, exc_code);
    end
    for (int u = 0; u < 4; u++)
    begin
      f = 25'($urandom);
      iss_cop_unit <= 2'(u);
      iss_cop_fun  <= f;
      iss_cp2_op   <= 4'(u + 1);
      step(1, ish_pkg::ISH_CLS_CP2, 0, 0, 0, 8'h40, 8'hC0);
      step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h02, 8'h02);
      chk("cop_sel", 4'b1 << u, cop_sel);
      chk("cop_fun", f, cop_fun);
    end
    step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h00, 8'h00);
    chk("far_fun", {4'h8, f}, {got_sel, got_fun});
    for (int k = 0; k < 2; k++)
    begin
      t = 5'($urandom);
      dly           <= 4'(5 * k);
      iss_sync_type <= t;
      step(1, ish_pkg::ISH_CLS_SYNC, 0, 0, 0, 8'h40, 8'hC0);
      step(1, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h01, 8'h41);
      chk("sync_type", t, sync_type);
      n = 0;
      while (last[0] === 1'b1 && n < 40)
      begin
        step(0, ish_pkg::ISH_CLS_INT, 0, 0, 0, 8'h00, 8'h00);
        n++;
      end
      chk("sync_count", k + 1, n_sync);
      chk("sync_wait", 1'b1, n >= 5 * k);
    end
    apb(1, ish_pkg::ADDR_STATUS, 32'h8000_0008);
    apb(0, ish_pkg::ADDR_STATUS, 0);
    chk("status", 32'h8000_0000, r & 32'h8000_0008);
    chk("addr64_on", 1'b1, addr64_en);
    apb(1, ish_pkg::ADDR_STATUS, 32'h0);
    repeat (2) @(posedge mclk);
    chk("addr64_off", 1'b0, addr64_en);
    conclude();
  end
endmodule
`default_nettype wire
